// ===== swr_pkg.sv
// Purpose: Shared constants for the sensor reset and watchdog supervisor.
// Assumes: 40 MHz clock, one clock domain.
// Notes:   The watchdog timeout is a default; the top module takes it as a
//          parameter so a simulation can shorten it.
`default_nettype none
package swr_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned WDOG_PERIOD_US   = 1000;
  localparam int unsigned WDOG_CYCLES      =
    (WDOG_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_PULSE_NS     = 1000;
  localparam int unsigned IRQ_PULSE_CYCLES =
    (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WARM_HOLD_NS     = 2000;
  localparam int unsigned WARM_HOLD_CYCLES =
    (WARM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 32;
  localparam int unsigned STRAP_WAIT_CYCLES = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_WDOG_EN   = 1'b0;
  localparam logic RST_KICK_LVL  = 1'b0;
  localparam logic RST_WARM_IND  = 1'b0;
  localparam logic RST_FAULT_OE  = 1'b0;

  typedef enum logic [1:0] {
    SWR_BOOT_UPDATE,
    SWR_BOOT_FUNCTIONAL
  } swr_boot_e;

  typedef enum {
    SWR_ST_BOOT,
    SWR_ST_RUN,
    SWR_ST_WARM
  } swr_state_e;
endpackage : swr_pkg
`default_nettype wire

// ===== swr_sync.sv
// Purpose: Two-flop synchroniser for one pin level.
// Assumes: Input is asynchronous to clk_in.
// Notes:   First stage feeds only the second stage.
`default_nettype none
module swr_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // swr_sync
`default_nettype wire

// ===== swr_supervisor.sv
// Purpose: Sensor-side reset, watchdog, boot and fault signalling logic.
// Assumes: reset_in is the synchronised external reset (low pin inverted).
// Notes:   Internal watchdog and external kick may both be used; the kick
//          toggles only when software asks and no blocked fault is active.
//
// Summary of operation
// - Missed internal watchdog restart triggers a warm reset of sensor.
// - Warm reset drives the soft restart indication output.
// - Detected internal error drives the fault indication output.
// - Soft restart indication clears once software has restarted.
// - Internal watchdog disabled after reset until software enables it.
// - Software toggles kick output toward external supervisor before timeout.
// - Optionally an active fault suppresses the kick toggle.
// - After boot the sensor pulses its attention interrupt to host.
// - Sensor samples boot_select to choose flash update or functional.
// - Fault output active low, open drain; pull-up holds idle level.
`default_nettype none
module swr_supervisor
  import swr_pkg::*;
#(
  parameter int unsigned WDOG_TIMEOUT = swr_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Boot strap pin
  input  wire logic boot_select_in,
  // Software controls from the main control cpu
  input  wire logic wdog_enable_in,
  input  wire logic wdog_restart_in,
  input  wire logic kick_request_in,
  input  wire logic fault_blocks_kick_in,
  input  wire logic boot_done_in,
  input  wire logic sw_restarted_in,
  input  wire logic fault_detect_in,
  // Status towards the control cpu
  output logic      boot_functional_out,
  output logic      warm_reset_req_out,
  // Pins
  output logic      watchdog_kick_out,
  output logic      soft_restart_indication_out,
  output logic      fault_indication_out,
  output logic      fault_indication_oe_out,
  output logic      sensor_attention_irq_out
);
  import swr_pkg::*;

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic boot_sel_sync;
  swr_sync u_boot_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (boot_select_in),
    .sync_out (boot_sel_sync)
  );

  swr_state_e     state_q,  state_d;
  logic           wdog_en_q, wdog_en_d;
  logic [CNT_W-1:0] wcnt_q, wcnt_d;
  logic [CNT_W-1:0] hold_q, hold_d;
  logic [CNT_W-1:0] irq_q,  irq_d;
  logic           strap_done_q, strap_done_d;
  logic [1:0]     strap_cnt_q, strap_cnt_d;
  logic           boot_fn_q, boot_fn_d;
  logic           kick_q, kick_d;
  logic           warm_q, warm_d;
  logic           wreq_q, wreq_d;
  logic           fault_oe_q, fault_oe_d;
  logic           irq_out_q, irq_out_d;
  logic           timeout;

  // Timeout only while armed; software must opt in after every reset
  assign timeout = wdog_en_q && (wcnt_q == CNT_W'(WDOG_TIMEOUT - 1));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d      = state_q;
    wdog_en_d    = wdog_en_q;
    wcnt_d       = wcnt_q;
    hold_d       = hold_q;
    irq_d        = irq_q;
    strap_done_d = strap_done_q;
    strap_cnt_d  = strap_cnt_q;
    boot_fn_d    = boot_fn_q;
    kick_d       = kick_q;
    warm_d       = warm_q;
    wreq_d       = 1'b0;
    fault_oe_d   = fault_detect_in;
    irq_out_d    = (irq_q != '0);

    // Strap sampled once, first cycle after the sync has settled
    // Sync flops are reset too; wait until both hold the pin
    if (!strap_done_q) begin
      if (strap_cnt_q == 2'(STRAP_WAIT_CYCLES)) begin
        boot_fn_d    = boot_sel_sync;
        strap_done_d = 1'b1;
      end else begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end
    end

    // Kick toggles on request unless a fault is allowed to block it
    if (kick_request_in && !(fault_blocks_kick_in && fault_detect_in)) begin
      kick_d = ~kick_q;
    end

    if (irq_q != '0) begin
      irq_d = irq_q - CNT_W'(1);
    end

    case (state_q)
      SWR_ST_BOOT: begin
        if (boot_done_in) begin
          irq_d   = CNT_W'(IRQ_PULSE_CYCLES);
          state_d = SWR_ST_RUN;
        end
      end
      SWR_ST_RUN: begin
        if (wdog_enable_in) begin
          wdog_en_d = 1'b1;
        end
        if (!wdog_en_q || wdog_restart_in) begin
          wcnt_d = '0;
        end else begin
          wcnt_d = wcnt_q + CNT_W'(1);
        end
        if (timeout) begin
          state_d   = SWR_ST_WARM;
          warm_d    = 1'b1;
          wreq_d    = 1'b1;
          wdog_en_d = RST_WDOG_EN;
          wcnt_d    = '0;
          hold_d    = CNT_W'(WARM_HOLD_CYCLES);
        end
        // Set wins over a same-cycle restart clear
        if (warm_q && sw_restarted_in && !timeout) begin
          warm_d = 1'b0;
        end
      end
      SWR_ST_WARM: begin
        // Internal reset holds the cpu; then software reboots
        wreq_d = (hold_q != '0);
        if (hold_q != '0) begin
          hold_d = hold_q - CNT_W'(1);
        end else begin
          state_d = SWR_ST_BOOT;
        end
      end
      default: state_d = SWR_ST_BOOT;
    endcase

    // Indication outlives the reset until restart; clears in boot too
    if (state_q == SWR_ST_BOOT && warm_q && sw_restarted_in) begin
      warm_d = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q      <= SWR_ST_BOOT;
      wdog_en_q    <= RST_WDOG_EN;
      wcnt_q       <= '0;
      hold_q       <= '0;
      irq_q        <= '0;
      strap_done_q <= 1'b0;
      strap_cnt_q  <= '0;
      boot_fn_q    <= 1'b0;
      kick_q       <= RST_KICK_LVL;
      warm_q       <= RST_WARM_IND;
      wreq_q       <= 1'b0;
      fault_oe_q   <= RST_FAULT_OE;
      irq_out_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      wdog_en_q    <= wdog_en_d;
      wcnt_q       <= wcnt_d;
      hold_q       <= hold_d;
      irq_q        <= irq_d;
      strap_done_q <= strap_done_d;
      strap_cnt_q  <= strap_cnt_d;
      boot_fn_q    <= boot_fn_d;
      kick_q       <= kick_d;
      warm_q       <= warm_d;
      wreq_q       <= wreq_d;
      fault_oe_q   <= fault_oe_d;
      irq_out_q    <= irq_out_d;
    end
  end

  // Open drain: never drives high, pull-up gives idle level
  assign fault_indication_out        = 1'b0;
  assign fault_indication_oe_out     = fault_oe_q;
  assign watchdog_kick_out           = kick_q;
  assign soft_restart_indication_out = warm_q;
  assign sensor_attention_irq_out    = irq_out_q;
  assign boot_functional_out         = boot_fn_q;
  assign warm_reset_req_out          = wreq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_wdog_off_reset: assert property (
    $past(reset_in) |-> !wdog_en_q)
    else $error("watchdog armed out of reset");
  a_timeout_warm: assert property (
    timeout && state_q == SWR_ST_RUN |=> warm_reset_req_out
      && state_q == SWR_ST_WARM)
    else $error("timeout did not start warm reset");
  a_warm_ind: assert property (
    warm_reset_req_out |-> soft_restart_indication_out)
    else $error("warm reset without indication");
  a_warm_release: assert property (
    soft_restart_indication_out && sw_restarted_in
      && state_q != SWR_ST_WARM && !timeout
      |=> !soft_restart_indication_out)
    else $error("indication not released after restart");
  a_fault_pin: assert property (
    fault_detect_in |=> fault_indication_oe_out
      && !fault_indication_out)
    else $error("fault not signalled low");
  a_kick_toggle: assert property (
    kick_request_in && !fault_detect_in
      |=> watchdog_kick_out != $past(watchdog_kick_out))
    else $error("kick did not toggle");
  a_kick_block: assert property (
    kick_request_in && fault_detect_in && fault_blocks_kick_in
      |=> $stable(watchdog_kick_out))
    else $error("fault did not block kick");
  a_boot_irq: assert property (
    boot_done_in && state_q == SWR_ST_BOOT
      |=> ##1 sensor_attention_irq_out [*8])
    else $error("boot interrupt pulse missing");
  a_strap_hold: assert property (
    strap_done_q |=> $stable(boot_functional_out))
    else $error("boot mode changed after sampling");

  c_warm: cover property (state_q == SWR_ST_WARM);
  c_boot_irq: cover property (sensor_attention_irq_out);
  c_kick_blocked: cover property (kick_request_in && fault_detect_in
    && fault_blocks_kick_in);
endmodule // swr_supervisor
`default_nettype wire

// ===== swr_host_model.sv
// Purpose: Host and supply model that sequences the sensor reset pins.
// Assumes: One sensor, one regulator, sensor clock shared with the host.
// Notes:   Strap shows the wrong mode while unpowered, to catch early use.
`default_nettype none
module swr_host_model #(
  parameter int unsigned SETTLE     = 4,
  parameter int unsigned BOOT_LIMIT = 100,
  parameter int unsigned KICK_LIMIT = 30,
  parameter int unsigned HOLD       = 8
) (
  // Clock
  input  wire logic clk_in,
  // Requests from the bench
  input  wire logic supply_ok_in,
  input  wire logic mode_functional_in,
  input  wire logic ext_wdog_arm_in,
  // Sensor pins
  input  wire logic attention_irq_in,
  input  wire logic kick_in,
  input  wire logic restart_ind_in,
  input  wire logic fault_pin_in,
  output logic      sensor_reset_out,
  output logic      boot_select_out,
  // Status
  output logic      boot_late_out,
  output logic      init_bad_out,
  output logic      fault_irq_out
);
  int unsigned settle_q    = 0;
  int unsigned boot_q      = 0;
  int unsigned kick_q      = 0;
  int unsigned hold_q      = 0;
  logic        booted_q    = 1'b0;
  logic        kick_seen_q = 1'b0;
  logic        irq_seen_q  = 1'b0;

  initial begin
    sensor_reset_out = 1'b1;
    boot_select_out  = 1'b0;
    boot_late_out    = 1'b0;
    init_bad_out     = 1'b0;
    fault_irq_out    = 1'b0;
  end

  always @(posedge clk_in) begin
    kick_seen_q <= kick_in;
    irq_seen_q  <= attention_irq_in;
    if (!supply_ok_in) begin
      // Reset held until power is good
      sensor_reset_out <= 1'b1;
      boot_select_out  <= ~mode_functional_in;
      settle_q         <= 0;
      boot_q           <= 0;
      booted_q         <= 1'b0;
      boot_late_out    <= 1'b0;
      kick_q           <= 0;
      hold_q           <= 0;
      init_bad_out     <= 1'b0;
      fault_irq_out    <= 1'b0;
    end else if (hold_q != 0) begin
      // Reset held for HOLD cycles after a missed kick or a boot overrun
      sensor_reset_out <= 1'b1;
      hold_q           <= hold_q - 1;
      settle_q         <= 0;
      boot_q           <= 0;
      booted_q         <= 1'b0;
      kick_q           <= 0;
    end else if (settle_q < SETTLE) begin
      // Mode lines settle before reset release
      boot_select_out <= mode_functional_in;
      settle_q        <= settle_q + 1;
    end else begin
      // Released only with supply good, no watchdog reset
      sensor_reset_out <= 1'b0;
      // Status pins checked as the boot interrupt arrives
      if (attention_irq_in && !irq_seen_q) begin
        init_bad_out <= restart_ind_in || !fault_pin_in;
      end
      // Fault pin taken as interrupt; status read not modelled
      if (!fault_pin_in) begin
        fault_irq_out <= 1'b1;
      end
      // Kick withheld or missed: supervisor resets sensor
      if (!ext_wdog_arm_in || kick_in != kick_seen_q) begin
        kick_q <= 0;
      end else begin
        kick_q <= kick_q + 1;
      end
      if (ext_wdog_arm_in && kick_q == KICK_LIMIT) begin
        sensor_reset_out <= 1'b1;
        hold_q           <= HOLD;
      end
      // Boot completion timer for this sensor only
      if (attention_irq_in) begin
        booted_q <= 1'b1;
      end else if (!booted_q && boot_q < BOOT_LIMIT) begin
        boot_q <= boot_q + 1;
      end
      // Overrun: recovery resets this sensor
      if (!booted_q && boot_q == BOOT_LIMIT) begin
        boot_late_out    <= 1'b1;
        sensor_reset_out <= 1'b1;
        hold_q           <= HOLD;
      end
    end
  end
endmodule // swr_host_model
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the sensor supervisor.
// Assumes: Host model owns the reset and strap pins.
// Notes:   Watchdog shortened to 20 cycles to keep the run short.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import swr_pkg::*;
  localparam int WD = 20;
  localparam int KL = 30, HD = 8, ST = 4, BL = 100;
  logic clk = 0, supply = 0, mode = 1, ext = 0, prev_k;
  logic en = 0, rst_sw = 0, kick = 0, blk = 0, done = 0, swr = 0, flt = 0;
  wire logic rst, bsel, late, fdat, foe, irq, warm, ind, kout, bfun;
  wire logic ibad, fseen;
  // Pull-up holds the idle level
  wire logic pin = foe ? fdat : 1'b1;
  int errors = 0, compares = 0, cyc = 0, dly, wid;
  // Rows: fault, block option, expected kick toggle
  logic [2:0] rows [4] = '{3'b001, 3'b011, 3'b101, 3'b110};

  swr_supervisor #(.WDOG_TIMEOUT(WD)) u_swr_supervisor (
    .clk_in(clk), .reset_in(rst), .boot_select_in(bsel),
    .wdog_enable_in(en), .wdog_restart_in(rst_sw), .kick_request_in(kick),
    .fault_blocks_kick_in(blk), .boot_done_in(done),
    .sw_restarted_in(swr), .fault_detect_in(flt),
    .boot_functional_out(bfun), .warm_reset_req_out(warm),
    .watchdog_kick_out(kout), .soft_restart_indication_out(ind),
    .fault_indication_out(fdat), .fault_indication_oe_out(foe),
    .sensor_attention_irq_out(irq));
  swr_host_model #(.SETTLE(ST), .BOOT_LIMIT(BL), .KICK_LIMIT(KL),
    .HOLD(HD)) u_swr_host_model (
    .clk_in(clk), .supply_ok_in(supply), .mode_functional_in(mode),
    .ext_wdog_arm_in(ext), .attention_irq_in(irq), .kick_in(kout),
    .restart_ind_in(ind), .fault_pin_in(pin), .sensor_reset_out(rst),
    .boot_select_out(bsel), .boot_late_out(late),
    .init_bad_out(ibad), .fault_irq_out(fseen));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi,
                       input string m);
    compares++;
    if (got < lo || got > hi) begin
      errors++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, got);
    end
  endtask
  // Clears every one-cycle request after the first edge
  task automatic measure(input logic w);
    dly = 0;
    wid = 0;
    do begin
      step(1);
      {en, rst_sw, kick, done, swr} = '0;
      dly++;
    end while ((w ? warm : irq) !== 1'b1 && dly < 200);
    while ((w ? warm : irq) === 1'b1 && wid < 200) begin
      step(1);
      wid++;
    end
  endtask
  task automatic wait_rst(input logic v);
    dly = 0;
    while (rst !== v && dly < 300) begin
      step(1);
      dly++;
    end
  endtask
  task automatic power_up(input logic m);
    supply = 0;
    mode = m;
    step(5);
    chk(warm | kout | ind | foe | irq | fdat, 1'b0, "idle in reset");
    supply = 1;
    wait_rst(1'b0);
    step(3);
    chk(bfun, m, "strap capture");
    chk(warm | kout | ind | foe | irq | fdat, 1'b0, "idle after release");
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    power_up(1'b1);
    step(3 * WD);
    chk(warm, 1'b0, "watchdog off by default");
    done = 1;
    measure(1'b0);
    chk_n(dly, 2, 2, "irq delay");
    chk_n(wid, IRQ_PULSE_CYCLES, IRQ_PULSE_CYCLES, "irq width");
    chk(ibad | fseen, 1'b0, "init status clean");
    done = 1;
    measure(1'b0);
    chk_n(dly, 200, 200, "boot done outside boot");
    foreach (rows[i]) begin
      {flt, blk} = rows[i][2:1];
      step(1);
      prev_k = kout;
      kick = 1;
      step(1);
      kick = 0;
      chk(kout, prev_k ^ rows[i][0], "kick toggle");
      chk(foe, flt, "fault enable");
      chk(pin, ~flt, "fault pin level");
    end
    chk(fseen, 1'b1, "fault interrupt");
    flt = 0;
    en = 1;
    step(1);
    en = 0;
    repeat (6) begin
      rst_sw = 1;
      step(1);
      rst_sw = 0;
      step(WD / 2);
    end
    chk(warm, 1'b0, "restarted in time");
    rst_sw = 1;
    measure(1'b1);
    chk_n(dly, WD - 2, WD + 3, "timeout");
    chk_n(wid, WARM_HOLD_CYCLES + 1, WARM_HOLD_CYCLES + 1, "warm");
    chk(ind, 1'b1, "restart indication");
    done = 1;
    measure(1'b0);
    chk_n(dly, 2, 2, "reboot irq");
    chk(ind, 1'b1, "indication held");
    chk(ibad, 1'b1, "init sees restart");
    swr = 1;
    step(1);
    swr = 0;
    chk(ind, 1'b0, "indication released");
    step(3 * WD);
    chk(warm, 1'b0, "timeout disarms");
    chk(late, 1'b0, "boot on time");
    ext = 1;
    repeat (3) begin
      kick = 1;
      step(1);
      kick = 0;
      step(KL / 2);
    end
    chk(rst, 1'b0, "kicked in time");
    wait_rst(1'b1);
    chk_n(dly, KL / 2 + 1, KL / 2 + 3, "missed kick");
    ext = 0;
    wait_rst(1'b0);
    chk_n(dly, HD + ST + 1, HD + ST + 1, "watchdog hold");
    wait_rst(1'b1);
    chk_n(dly, BL, BL, "boot overrun");
    chk(late, 1'b1, "late boot flagged");
    power_up(1'b0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
